// ---- rtl/crs_pkg.sv ----
// package for the cpu register set: register indices, widths, reset values
`default_nettype none
package crs_pkg;
    localparam int CRS_WORD_W = 16;
    localparam int CRS_BYTE_W = 8;
    localparam int CRS_PHYS_W = 20;
    localparam int CRS_SEG_SHIFT = 4;
    localparam int CRS_NUM_GEN = 8;
    localparam int CRS_NUM_SEG = 4;
    localparam int CRS_NUM_ARCH = 14;
    // general register indices
    localparam logic [2:0] CRS_ACC = 3'h0;
    localparam logic [2:0] CRS_CNT = 3'h1;
    localparam logic [2:0] CRS_PORT = 3'h2;
    localparam logic [2:0] CRS_BASE = 3'h3;
    localparam logic [2:0] CRS_STK = 3'h4;
    localparam logic [2:0] CRS_FRAME = 3'h5;
    localparam logic [2:0] CRS_SRC = 3'h6;
    localparam logic [2:0] CRS_DEST = 3'h7;
    // segment indices
    localparam logic [1:0] CRS_SEG_EXTRA = 2'h0;
    localparam logic [1:0] CRS_SEG_CODE = 2'h1;
    localparam logic [1:0] CRS_SEG_STACK = 2'h2;
    localparam logic [1:0] CRS_SEG_DATA = 2'h3;
    // reset values
    localparam logic [15:0] CRS_GEN_RST = 16'h0000;
    localparam logic [15:0] CRS_SEG_RST = 16'h0000;
    localparam logic [15:0] CRS_CODE_RST = 16'hffff;
    localparam logic [15:0] CRS_IP_RST = 16'h0000;
    localparam logic [15:0] CRS_FLAGS_RST = 16'h0000;
    localparam logic [15:0] CRS_FLAGS_MASK = 16'h0fd5;
    // write width selector
    typedef enum logic [1:0] {
        CRS_WR_WORD = 2'b00,
        CRS_WR_LOW = 2'b01,
        CRS_WR_HIGH = 2'b10
    } crs_wsize_e;
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        crs_wsize_e size;
        logic [15:0] data;
    } crs_gen_wr_s;
    typedef struct packed {
        logic en;
        logic [1:0] idx;
        logic [15:0] data;
    } crs_seg_wr_s;
    // address request: segment, base and index sources, displacement
    typedef struct packed {
        logic stack_op;
        logic [1:0] seg_idx;
        logic use_base;
        logic base_frame;
        logic use_index;
        logic index_dest;
        logic [15:0] disp;
    } crs_addr_req_s;
endpackage : crs_pkg
`default_nettype wire

// ---- rtl/crs_regfile.sv ----
// architectural register set with operand reads, writes and address generation
`default_nettype none
// Operation
// - fourteen registers: eight general, four segment, instruction pointer, status word.
// - eight 16-bit general registers serve as operands.
// - accumulator, base, count and port words split into high and low byte halves.
// - destination and source index registers serve as data movement pointers.
// - stack pointer lives within the stack segment; frame base pointer uses the requested segment.
// - frame base, base word, destination and source index supply offset parts.
// - stack operations always use stack pointer with stack segment, no override.
// - four 16-bit segment registers select code, two data and stack segments.
// - the 16-bit instruction pointer holds the next sequential instruction offset.
// - a 16-bit status word holds result status and control bits.
// - peripheral registers are not held here; they sit behind memory accesses.
// - physical address is segment shifted left by four plus the offset.
// - the physical address is 20 bits wide.
module crs_regfile
    import crs_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire crs_gen_wr_s gen_wr_i,
    input wire crs_seg_wr_s seg_wr_i,
    input wire logic ip_wr_i,
    input wire logic [15:0] ip_data_i,
    input wire logic flags_wr_i,
    input wire logic [15:0] flags_data_i,
    input wire logic [2:0] rd_a_idx_i,
    input wire logic rd_a_byte_i,
    input wire logic [2:0] rd_b_idx_i,
    input wire logic rd_b_byte_i,
    input wire crs_addr_req_s addr_req_i,
    output logic [15:0] rd_a_o,
    output logic [15:0] rd_b_o,
    output logic [19:0] phys_addr_o,
    output logic [15:0] ip_o,
    output logic [15:0] flags_o,
    output logic [15:0] stack_ptr_o
);
    logic [15:0] gen_r [CRS_NUM_GEN];
    logic [15:0] seg_r [CRS_NUM_SEG];
    logic [15:0] ip_r;
    logic [15:0] flags_r;
    logic [15:0] rd_a_r;
    logic [15:0] rd_b_r;
    logic [19:0] phys_r;

    // byte read: index 0-3 low halves, 4-7 high halves of words 0-3
    function automatic logic [15:0] crs_read(input logic [2:0] idx, input logic byte_sel,
                                             input logic [15:0] g0, input logic [15:0] g1,
                                             input logic [15:0] g2, input logic [15:0] g3,
                                             input logic [15:0] gw);
        logic [15:0] w;
        w = 16'h0000;
        if (!byte_sel) begin
            w = gw;
        end else begin
            case (idx[1:0])
                2'h0: w = g0;
                2'h1: w = g1;
                2'h2: w = g2;
                default: w = g3;
            endcase
            w = idx[2] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end
        return w;
    endfunction : crs_read

    // byte writes map onto word index low bits, matching the read mapping
    genvar gi;
    generate
        for (gi = 0; gi < CRS_NUM_GEN; gi++) begin : g_gen
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    gen_r[gi] <= CRS_GEN_RST;
                end else if (gen_wr_i.en) begin
                    if (gen_wr_i.size == CRS_WR_WORD && gen_wr_i.idx == 3'(gi)) begin
                        gen_r[gi] <= gen_wr_i.data;
                    end else if (gi < 4 && gen_wr_i.idx[1:0] == 2'(gi)
                                 && gen_wr_i.size == CRS_WR_LOW) begin
                        gen_r[gi][7:0] <= gen_wr_i.data[7:0];
                    end else if (gi < 4 && gen_wr_i.idx[1:0] == 2'(gi)
                                 && gen_wr_i.size == CRS_WR_HIGH) begin
                        gen_r[gi][15:8] <= gen_wr_i.data[7:0];
                    end
                end
            end
        end
        for (gi = 0; gi < CRS_NUM_SEG; gi++) begin : g_seg
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    seg_r[gi] <= (gi == 1) ? CRS_CODE_RST : CRS_SEG_RST;
                end else if (seg_wr_i.en && seg_wr_i.idx == 2'(gi)) begin
                    seg_r[gi] <= seg_wr_i.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ip_r <= CRS_IP_RST;
        end else if (ip_wr_i) begin
            ip_r <= ip_data_i;
        end
    end

    // reserved status bits always read zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags_r <= CRS_FLAGS_RST;
        end else if (flags_wr_i) begin
            flags_r <= flags_data_i & CRS_FLAGS_MASK;
        end
    end

    // registered read ports: value reflects state at the sampling edge
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_a_r <= 16'h0000;
            rd_b_r <= 16'h0000;
        end else begin
            rd_a_r <= crs_read(rd_a_idx_i, rd_a_byte_i, gen_r[0], gen_r[1], gen_r[2],
                               gen_r[3], gen_r[rd_a_idx_i]);
            rd_b_r <= crs_read(rd_b_idx_i, rd_b_byte_i, gen_r[0], gen_r[1], gen_r[2],
                               gen_r[3], gen_r[rd_b_idx_i]);
        end
    end

    // address generation; stack ops ignore segment and sources requested
    logic [15:0] base_v;
    logic [15:0] index_v;
    logic [15:0] offset_v;
    logic [15:0] seg_v;
    always_comb begin
        base_v = 16'h0000;
        index_v = 16'h0000;
        if (addr_req_i.use_base) begin
            base_v = addr_req_i.base_frame ? gen_r[CRS_FRAME] : gen_r[CRS_BASE];
        end
        if (addr_req_i.use_index) begin
            index_v = addr_req_i.index_dest ? gen_r[CRS_DEST] : gen_r[CRS_SRC];
        end
        if (addr_req_i.stack_op) begin
            offset_v = gen_r[CRS_STK] + addr_req_i.disp;
            seg_v = seg_r[CRS_SEG_STACK];
        end else begin
            offset_v = base_v + index_v + addr_req_i.disp;
            seg_v = seg_r[addr_req_i.seg_idx];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            phys_r <= 20'h0_0000;
        end else begin
            phys_r <= 20'({seg_v, 4'h0}) + 20'(offset_v);
        end
    end

    assign rd_a_o = rd_a_r;
    assign rd_b_o = rd_b_r;
    assign phys_addr_o = phys_r;
    assign ip_o = ip_r;
    assign flags_o = flags_r;
    assign stack_ptr_o = gen_r[CRS_STK];

    // no peripheral storage here, only the fourteen registers above

    property p_word_write;
        @(posedge clock_i) disable iff (!rst_n_i)
        (gen_wr_i.en && gen_wr_i.size == CRS_WR_WORD) |=> gen_r[$past(gen_wr_i.idx)]
            == $past(gen_wr_i.data);
    endproperty
    a_word_write: assert property (p_word_write) else $error("word write lost");
    property p_low_keep;
        @(posedge clock_i) disable iff (!rst_n_i)
        (gen_wr_i.en && gen_wr_i.size == CRS_WR_LOW && gen_wr_i.idx == CRS_ACC)
            |=> gen_r[CRS_ACC][15:8] == $past(gen_r[CRS_ACC][15:8])
            && gen_r[CRS_ACC][7:0] == $past(gen_wr_i.data[7:0]);
    endproperty
    a_low_keep: assert property (p_low_keep) else $error("low byte write wrong");
    property p_high_keep;
        @(posedge clock_i) disable iff (!rst_n_i)
        (gen_wr_i.en && gen_wr_i.size == CRS_WR_HIGH && gen_wr_i.idx[1:0] == CRS_PORT[1:0])
            |=> gen_r[CRS_PORT][7:0] == $past(gen_r[CRS_PORT][7:0]);
    endproperty
    a_high_keep: assert property (p_high_keep) else $error("high write hit low");
    property p_stack_addr;
        @(posedge clock_i) disable iff (!rst_n_i)
        (addr_req_i.stack_op && !seg_wr_i.en) |=> phys_addr_o ==
            20'({$past(seg_r[CRS_SEG_STACK]), 4'h0})
            + 20'(16'($past(gen_r[CRS_STK]) + $past(addr_req_i.disp)));
    endproperty
    a_stack_addr: assert property (p_stack_addr) else $error("stack segment not used");
    property p_phys;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!addr_req_i.stack_op && !addr_req_i.use_base && !addr_req_i.use_index)
            |=> phys_addr_o == 20'({$past(seg_r[addr_req_i.seg_idx]), 4'h0})
            + 20'($past(addr_req_i.disp));
    endproperty
    a_phys: assert property (p_phys) else $error("physical address wrong");
    property p_ip;
        @(posedge clock_i) disable iff (!rst_n_i)
        ip_wr_i |=> ip_o == $past(ip_data_i);
    endproperty
    a_ip: assert property (p_ip) else $error("ip not loaded");
    property p_flags_rsv;
        @(posedge clock_i) disable iff (!rst_n_i)
        flags_wr_i |=> (flags_o & ~CRS_FLAGS_MASK) == 16'h0000
            && flags_o == ($past(flags_data_i) & CRS_FLAGS_MASK);
    endproperty
    a_flags_rsv: assert property (p_flags_rsv) else $error("status word wrong");
    property p_seg;
        @(posedge clock_i) disable iff (!rst_n_i)
        seg_wr_i.en |=> seg_r[$past(seg_wr_i.idx)] == $past(seg_wr_i.data);
    endproperty
    a_seg: assert property (p_seg) else $error("segment write lost");
    property p_rd_a;
        @(posedge clock_i) disable iff (!rst_n_i)
        !rd_a_byte_i |=> rd_a_o == $past(gen_r[rd_a_idx_i]);
    endproperty
    a_rd_a: assert property (p_rd_a) else $error("read port a wrong");
    c_byte: cover property (@(posedge clock_i) gen_wr_i.en && gen_wr_i.size == CRS_WR_HIGH);
    c_stack: cover property (@(posedge clock_i) addr_req_i.stack_op);
    c_two: cover property (@(posedge clock_i) gen_wr_i.en ##2 rd_a_byte_i && rd_b_byte_i);
endmodule : crs_regfile
`default_nettype wire

// ---- testbench/crs_exec_model.sv ----
// execution unit model issuing register writes, operand reads and address requests
`default_nettype none
module crs_exec_model
    import crs_pkg::*;
(
    input wire logic clock_i,
    input wire logic [15:0] rd_a_i,
    input wire logic [15:0] rd_b_i,
    input wire logic [19:0] phys_i,
    output var crs_gen_wr_s gen_wr_o,
    output var crs_seg_wr_s seg_wr_o,
    output logic ip_wr_o,
    output logic [15:0] ip_data_o,
    output logic flags_wr_o,
    output logic [15:0] flags_data_o,
    output logic [2:0] rd_a_idx_o,
    output logic rd_a_byte_o,
    output logic [2:0] rd_b_idx_o,
    output logic rd_b_byte_o,
    output var crs_addr_req_s addr_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        gen_wr_o = '0;
        seg_wr_o = '0;
        {ip_wr_o, ip_data_o, flags_wr_o, flags_data_o} = '0;
        {rd_a_idx_o, rd_a_byte_o, rd_b_idx_o, rd_b_byte_o} = '0;
        addr_req_o = '0;
    end
    // one write per clock: the enable is held for exactly one rising edge
    task automatic gen(input logic [2:0] idx, input crs_wsize_e sz, input logic [15:0] d);
        @(negedge clock_i);
        gen_wr_o = '{en: 1'b1, idx: idx, size: sz, data: d};
        @(negedge clock_i);
        gen_wr_o.en = 1'b0;
    endtask : gen
    task automatic seg(input logic [1:0] idx, input logic [15:0] d);
        @(negedge clock_i);
        seg_wr_o = '{en: 1'b1, idx: idx, data: d};
        @(negedge clock_i);
        seg_wr_o.en = 1'b0;
    endtask : seg
    task automatic ipf(input logic [15:0] ip, input logic [15:0] fl);
        @(negedge clock_i);
        {ip_wr_o, ip_data_o, flags_wr_o, flags_data_o} = {1'b1, ip, 1'b1, fl};
        @(negedge clock_i);
        {ip_wr_o, flags_wr_o} = 2'b00;
    endtask : ipf
    // read data is registered, so it is taken one falling edge after the select
    task automatic rd(input logic [3:0] a, input logic [3:0] b, output logic [15:0] qa,
                      output logic [15:0] qb);
        @(negedge clock_i);
        {rd_a_byte_o, rd_a_idx_o, rd_b_byte_o, rd_b_idx_o} = {a, b};
        @(negedge clock_i);
        qa = rd_a_i;
        qb = rd_b_i;
    endtask : rd
    task automatic addr(input crs_addr_req_s r, output logic [19:0] p);
        @(negedge clock_i);
        addr_req_o = r;
        @(negedge clock_i);
        p = phys_i;
    endtask : addr
endmodule : crs_exec_model
`default_nettype wire

// ---- testbench/tb_cpu_register_set.sv ----
// self-checking bench for the cpu register set
`default_nettype none
module tb_cpu_register_set
    import crs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    int n_mismatch = 0;
    int check_count = 0;
    crs_gen_wr_s gen_wr;
    crs_seg_wr_s seg_wr;
    crs_addr_req_s areq;
    logic ip_wr;
    logic flags_wr;
    logic [15:0] ip_data;
    logic [15:0] flags_data;
    logic [2:0] ra_idx;
    logic [2:0] rb_idx;
    logic ra_byte;
    logic rb_byte;
    logic [15:0] rd_a;
    logic [15:0] rd_b;
    logic [15:0] ip;
    logic [15:0] flags;
    logic [15:0] sp;
    logic [19:0] phys;
    always #12.5 clock_i = ~clock_i;
    crs_regfile i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .gen_wr_i(gen_wr),
        .seg_wr_i(seg_wr), .ip_wr_i(ip_wr), .ip_data_i(ip_data), .flags_wr_i(flags_wr),
        .flags_data_i(flags_data), .rd_a_idx_i(ra_idx), .rd_a_byte_i(ra_byte),
        .rd_b_idx_i(rb_idx), .rd_b_byte_i(rb_byte), .addr_req_i(areq), .rd_a_o(rd_a),
        .rd_b_o(rd_b), .phys_addr_o(phys), .ip_o(ip), .flags_o(flags), .stack_ptr_o(sp));
    crs_exec_model i_exec (.clock_i(clock_i), .rd_a_i(rd_a), .rd_b_i(rd_b), .phys_i(phys),
        .gen_wr_o(gen_wr), .seg_wr_o(seg_wr), .ip_wr_o(ip_wr), .ip_data_o(ip_data),
        .flags_wr_o(flags_wr), .flags_data_o(flags_data), .rd_a_idx_o(ra_idx),
        .rd_a_byte_o(ra_byte), .rd_b_idx_o(rb_idx), .rd_b_byte_o(rb_byte), .addr_req_o(areq));
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        chk({4'h0, got}, {4'h0, exp});
    endtask : chk16
    task automatic summarize();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic t_words();
        logic [15:0] qa;
        logic [15:0] qb;
        for (int i = 0; i < 8; i++) begin
            i_exec.gen(3'(i), CRS_WR_WORD, 16'(16'h1111 * (i + 1)));
        end
        for (int i = 0; i < 8; i++) begin
            i_exec.rd(4'(i), 4'(7 - i), qa, qb);
            chk16(qa, 16'(16'h1111 * (i + 1)));
            chk16(qb, 16'(16'h1111 * (8 - i)));
        end
    endtask : t_words
    // upper data bits are junk on byte writes, only the low byte may land
    task automatic t_bytes();
        logic [15:0] qa;
        logic [15:0] qb;
        for (int w = 0; w < 4; w++) begin
            i_exec.gen(3'(w), CRS_WR_LOW, 16'hff12);
            i_exec.rd(4'(w), 4'(8 + w), qa, qb);
            chk16(qa, 16'(16'h1111 * (w + 1)) & 16'hff00 | 16'h0012);
            chk16(qb, 16'h0012);
            i_exec.gen(3'(w), CRS_WR_HIGH, 16'hff34);
            i_exec.rd(4'(12 + w), 4'(8 + w), qa, qb);
            chk16(qa, 16'h0034);
            chk16(qb, 16'h0012);
            i_exec.rd(4'(w), 4'(w), qa, qb);
            chk16(qa, 16'h3412);
        end
    endtask : t_bytes
    task automatic t_addr();
        logic [19:0] p;
        i_exec.gen(CRS_BASE, CRS_WR_WORD, 16'h0100);
        i_exec.gen(CRS_FRAME, CRS_WR_WORD, 16'h0200);
        i_exec.gen(CRS_SRC, CRS_WR_WORD, 16'h0010);
        i_exec.gen(CRS_DEST, CRS_WR_WORD, 16'h0020);
        i_exec.gen(CRS_STK, CRS_WR_WORD, 16'h0040);
        i_exec.seg(CRS_SEG_DATA, 16'h12a4);
        i_exec.seg(CRS_SEG_EXTRA, 16'h1000);
        i_exec.seg(CRS_SEG_STACK, 16'h2000);
        chk16(sp, 16'h0040);
        i_exec.addr('{seg_idx: CRS_SEG_DATA, disp: 16'h0022, default: '0}, p);
        chk(p, 20'h1_2a62);
        i_exec.addr('{seg_idx: CRS_SEG_DATA, use_base: 1'b1, use_index: 1'b1,
                      disp: 16'h0002, default: '0}, p);
        chk(p, 20'h1_2b52);
        i_exec.addr('{seg_idx: CRS_SEG_EXTRA, use_base: 1'b1, base_frame: 1'b1,
                      use_index: 1'b1, index_dest: 1'b1, default: '0}, p);
        chk(p, 20'h1_0220);
        i_exec.addr('{stack_op: 1'b1, seg_idx: CRS_SEG_DATA, use_base: 1'b1,
                      use_index: 1'b1, disp: 16'h0004, default: '0}, p);
        chk(p, 20'h2_0044);
        i_exec.addr('{seg_idx: CRS_SEG_CODE, disp: 16'h0020, default: '0}, p);
        chk(p, 20'h0_0010);
    endtask : t_addr
    // mid-run reset must clear everything but the code segment
    task automatic t_ctl();
        logic [15:0] qa;
        logic [15:0] qb;
        logic [19:0] p;
        i_exec.ipf(16'h1234, 16'hffff);
        chk16(ip, 16'h1234);
        chk16(flags, 16'h0fd5);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        chk16(ip, CRS_IP_RST);
        chk16(flags, CRS_FLAGS_RST);
        chk16(sp, CRS_GEN_RST);
        i_exec.rd(4'h3, 4'h7, qa, qb);
        chk16(qa, CRS_GEN_RST);
        chk16(qb, CRS_GEN_RST);
        i_exec.addr('{seg_idx: CRS_SEG_DATA, disp: 16'h0022, default: '0}, p);
        chk(p, 20'h0_0022);
        i_exec.addr('{seg_idx: CRS_SEG_CODE, default: '0}, p);
        chk(p, 20'hf_fff0);
    endtask : t_ctl
    initial begin
        #(25 * 3000);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        chk16(ip, CRS_IP_RST);
        chk16(flags, CRS_FLAGS_RST);
        t_words();
        t_bytes();
        t_addr();
        t_ctl();
        summarize();
    end
endmodule : tb_cpu_register_set
`default_nettype wire
